//--- hdl/rss_supervisor.sv
// Supervisor: on/off source, protection timers, status pins and LEDs
`timescale 1ns/1ns
module rss_supervisor #(
    parameter longint unsigned STARTUP_CYC = rss_pkg::STARTUP_OVL_CYC,
    parameter longint unsigned RETRY_CYC = rss_pkg::OV_RESTART_DLY_CYC,
    parameter longint unsigned WINDOW_CYC = rss_pkg::OV_WINDOW_CYC,
    parameter int unsigned PULSE_CYC = 32'(rss_pkg::PG_PULSE_CYC),
    parameter int unsigned BLINK_HALF_CYC = 32'(rss_pkg::BLINK_CYC)
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Pins and switches (asynchronous, synchronised here)
    input wire logic mode_sel_n, // Low selects link (RS485) mode
    input wire logic enable_n, // Low turns output on
    input wire logic link_mode_output_switch, // High turns on in link mode
    input wire logic onoff_sw, // Rear on/off switch, high is on
    input wire logic trim_sw, // Rear trim switch, high is on
    // Power stage monitors (same clock domain)
    input wire logic input_ok, // Input present and in limits
    input wire logic input_present, // Input present at all
    input wire logic overload, // Output in current limit
    input wire logic ov_trip, // Overvoltage detected
    input wire logic oc_trip, // Overcurrent shutdown request
    input wire logic ot_warn, // Temperature near shutdown
    input wire logic ot_trip, // Temperature at shutdown
    input wire logic boost_fail, // Boost stage failed
    input wire logic nonfatal_fault, // Fault that keeps output on
    input wire logic cmd_off, // Bus command holds output off
    input wire logic service_req, // Service request (bus mode)
    input wire logic link_lost, // Link mode communication lost
    // Setpoint source selection
    output logic use_trim, // Local trim pot drives setpoint
    output logic use_margin, // Margin input drives setpoint
    output logic use_default, // Factory default setpoint
    output logic link_mode, // Link mode active
    output logic output_on, // Power stage enable
    output logic latched_off, // Overvoltage latch state
    // Open-drain status: drive low when enable high
    output logic output_good_flag_o,
    output logic output_good_flag_oe,
    output logic fault_o,
    output logic fault_oe,
    output logic overheat_warning_o,
    output logic overheat_warning_oe,
    // Indicators, high is lit
    output logic led_input_ok,
    output logic led_output_ok,
    output logic led_service,
    output logic led_fault
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst); // Checks sleep through reset
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two stages for every asynchronous pin
    localparam int NP = 5;
    logic [NP-1:0] pin_raw;
    logic [NP-1:0] pin_m_q;
    logic [NP-1:0] pin_s_q;
    assign pin_raw = {trim_sw, onoff_sw, link_mode_output_switch,
                      enable_n, mode_sel_n};

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_m_q <= 5'h13; // Idle levels, so no false on request
            pin_s_q <= 5'h13;
        end else if (clk_en) begin
            pin_m_q <= pin_raw;
            pin_s_q <= pin_m_q;
        end
    end

    // ----------------------------------------------------------------
    // Mode and on/off source
    // ----------------------------------------------------------------
    logic mode_link;
    logic req_on;
    assign mode_link = ~pin_s_q[0];
    // Switch on overrides the enable pin; link mode uses its own switch
    assign req_on = mode_link ? pin_s_q[2]
                  : (pin_s_q[3] | ~pin_s_q[1])
                  & ~cmd_off;
    assign link_mode = mode_link;

    // Setpoint source; trim pot default on, link mode overrides all
    assign use_trim = ~mode_link & pin_s_q[4];
    assign use_margin = ~mode_link & ~pin_s_q[4];
    assign use_default = mode_link | ~pin_s_q[4];

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    logic [31:0] st_cnt_q; // Startup overload timer
    logic [31:0] dly_cnt_q; // Restart delay timer
    logic [31:0] win_cnt_q; // Overvoltage window timer
    logic [1:0] ov_cnt_q; // Overvoltage shutdowns in window
    logic startup_q; // Still in power-up phase
    logic st_expire;
    logic dly_done;
    logic win_done;
    logic ov_shut_q; // Current shutdown came from overvoltage
    rss_pkg::rss_state_e state_q;
    rss_pkg::rss_state_e state_d;

    assign st_expire = (st_cnt_q == 32'(STARTUP_CYC - 1)) & overload;
    assign dly_done = (dly_cnt_q == 32'(RETRY_CYC - 1));
    assign win_done = (win_cnt_q == 32'(WINDOW_CYC - 1));

    // Fault shutdown sources while running
    logic trip_any;
    assign trip_any = ov_trip | oc_trip | ot_trip | boost_fail
                    | (startup_q & st_expire);
    // Third overvoltage in window latches off
    logic ov_latch;
    assign ov_latch = ov_trip
                    & (ov_cnt_q == 2'(rss_pkg::OV_MAX_TRIES - 1));

    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            rss_pkg::RSS_OFF: begin
                if (req_on && input_ok) begin
                    state_d = rss_pkg::RSS_RUN;
                end
            end
            rss_pkg::RSS_RUN: begin
                if (!req_on || !input_ok) begin
                    state_d = rss_pkg::RSS_OFF;
                end else if (ov_latch) begin
                    state_d = rss_pkg::RSS_LATCH;
                end else if (trip_any) begin
                    state_d = rss_pkg::RSS_SHUT;
                end
            end
            rss_pkg::RSS_SHUT: begin
                if (!req_on) begin
                    state_d = rss_pkg::RSS_OFF;
                end else if (dly_done && !ot_trip && input_ok) begin
                    state_d = rss_pkg::RSS_RUN;
                end
            end
            rss_pkg::RSS_LATCH: begin
                // Only an on/off cycle or reset leaves the latch
                if (!req_on) begin
                    state_d = rss_pkg::RSS_OFF;
                end
            end
            default: state_d = rss_pkg::RSS_OFF;
        endcase
    end

    // State register; power cycle is nrst
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= rss_pkg::RSS_OFF;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Startup allowance: counts overload time after first power-up
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_cnt_q <= '0;
            startup_q <= 1'b1;
        end else if (clk_en) begin
            if (state_q != rss_pkg::RSS_RUN) begin
                st_cnt_q <= '0;
            end else if (!overload) begin
                st_cnt_q <= '0;
                startup_q <= 1'b0; // Startup ends once load is carried
            end else if (st_expire) begin
                st_cnt_q <= '0;
            end else begin
                st_cnt_q <= st_cnt_q + 32'h1;
            end
        end
    end

    // Restart delay while shut down
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dly_cnt_q <= '0;
        end else if (clk_en) begin
            if (state_q != rss_pkg::RSS_SHUT || dly_done) begin
                dly_cnt_q <= '0;
            end else begin
                dly_cnt_q <= dly_cnt_q + 32'h1;
            end
        end
    end

    // Overvoltage count and one-minute window
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            win_cnt_q <= '0;
            ov_cnt_q <= '0;
            ov_shut_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == rss_pkg::RSS_OFF) begin
                win_cnt_q <= '0;
                ov_cnt_q <= '0;
                ov_shut_q <= 1'b0;
            end else begin
                if (state_q == rss_pkg::RSS_RUN && ov_trip) begin
                    ov_shut_q <= 1'b1;
                end else if (state_d == rss_pkg::RSS_RUN) begin
                    ov_shut_q <= 1'b0;
                end
                if (ov_cnt_q == 2'h0 && !(state_q == rss_pkg::RSS_RUN
                    && ov_trip)) begin
                    win_cnt_q <= '0;
                end else if (win_done) begin
                    win_cnt_q <= '0;
                    ov_cnt_q <= '0;
                end else begin
                    win_cnt_q <= win_cnt_q + 32'h1;
                    if (state_q == rss_pkg::RSS_RUN && ov_trip
                        && !ov_latch) begin
                        ov_cnt_q <= ov_cnt_q + 2'h1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pattern generators
    // ----------------------------------------------------------------
    logic blink;
    logic pulse;
    rss_tick #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .wave(blink)
    );
    rss_tick #(.HALF_CYC(PULSE_CYC)) u_pulse (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .wave(pulse)
    );

    // ----------------------------------------------------------------
    // Status decode
    // ----------------------------------------------------------------
    logic running;
    logic pg_act;
    logic fault_act;
    logic warn_act;
    logic ot_shut;
    assign running = (state_q == rss_pkg::RSS_RUN);
    assign ot_shut = (state_q == rss_pkg::RSS_SHUT) & ot_trip;
    // Good while delivered; pulsed in overload; low when off
    assign pg_act = running & ~(overload & pulse);
    // Fault pin unused in link mode
    assign fault_act = ~mode_link & (ot_shut
                     | (state_q == rss_pkg::RSS_LATCH)
                     | boost_fail | (ov_shut_q & ~running)
                     | nonfatal_fault);
    // Outside link mode, warning stays low through the thermal shutdown, released once ot_warn and ot_trip both clear
    assign warn_act = ~mode_link & (ot_warn | ot_trip);

    // Registered pin and LED drives
    logic pg_q, flt_q, otw_q;
    logic l_in_q, l_out_q, l_svc_q, l_flt_q;
    logic l_in_d, l_out_d, l_svc_d, l_flt_d;
    assign l_in_d = input_ok | (input_present & blink);
    assign l_out_d = running & (~overload | blink);
    assign l_svc_d = ot_warn | ot_trip
                   | (~mode_link & service_req & blink);
    assign l_flt_d = (fault_act & ~nonfatal_fault) | nonfatal_fault
                   | (mode_link & (ot_shut
                   | (state_q == rss_pkg::RSS_LATCH) | boost_fail))
                   | (mode_link & link_lost & blink);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pg_q <= 1'b0;
            flt_q <= 1'b0;
            otw_q <= 1'b0;
            {l_in_q, l_out_q, l_svc_q, l_flt_q} <= 4'h0;
        end else if (clk_en) begin
            pg_q <= pg_act;
            flt_q <= fault_act;
            otw_q <= warn_act;
            {l_in_q, l_out_q, l_svc_q, l_flt_q} <=
                {l_in_d, l_out_d, l_svc_d, l_flt_d};
        end
    end

    // Open drain: pull low for alarm, release for normal
    assign output_good_flag_o = 1'b0;
    assign output_good_flag_oe = ~pg_q;
    assign fault_o = 1'b0;
    assign fault_oe = flt_q;
    assign overheat_warning_o = 1'b0;
    assign overheat_warning_oe = otw_q;
    assign led_input_ok = l_in_q;
    assign led_output_ok = l_out_q;
    assign led_service = l_svc_q;
    assign led_fault = l_flt_q;
    assign output_on = running;
    assign latched_off = (state_q == rss_pkg::RSS_LATCH);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    latch_hold_a: assert property (
        (state_q == rss_pkg::RSS_LATCH) && req_on && clk_en
        |=> (state_q == rss_pkg::RSS_LATCH))
        else $error("latch released while on request held");
    latch_clear_a: assert property (
        (state_q == rss_pkg::RSS_LATCH) && !req_on && clk_en
        |=> (state_q == rss_pkg::RSS_OFF))
        else $error("latch not cleared by off request");
    pg_off_a: assert property (
        !running && clk_en |=> output_good_flag_oe)
        else $error("power good not low while off");
    fault_link_a: assert property (
        mode_link && $stable(mode_link) && clk_en |=> !fault_oe)
        else $error("fault pin driven in link mode");
    setpoint_sel_a: assert property (
        mode_link |-> use_default && !use_trim && !use_margin)
        else $error("setpoint source wrong in link mode");
    retry_wait_a: assert property (
        $rose(state_q == rss_pkg::RSS_SHUT) && clk_en
        |=> (state_q != rss_pkg::RSS_RUN))
        else $error("restart without delay");
    warn_drive_a: assert property (
        ot_warn && !mode_link && clk_en |=> overheat_warning_oe)
        else $error("warning not driven");
    ovl_led_a: assert property (
        !running && clk_en |=> !led_output_ok)
        else $error("output led lit while off");
endmodule // rss_supervisor

//--- hdl/rss_tick.sv
// Free-running square-wave generator used for blink and pulse patterns
`timescale 1ns/1ns
module rss_tick #(
    parameter int unsigned HALF_CYC = 10
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    output logic wave
);
    // Counter wide enough for one half period
    localparam int W = $clog2(HALF_CYC + 1);
    logic [W-1:0] cnt_q;
    logic wave_q;
    logic wrap;

    assign wrap = (cnt_q == W'(HALF_CYC - 1));
    assign wave = wave_q;

    // Toggle once per half period
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt_q <= '0;
            wave_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            if (wrap) begin
                wave_q <= ~wave_q;
            end
        end
    end
endmodule // rss_tick

//--- inc/rss_pkg.sv
// Shared constants for the rectifier supervisor status logic
package rss_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000; // 50 ns period
    localparam int unsigned STARTUP_OVL_S = 20; // Startup overload allowance
    localparam int unsigned OV_RESTART_DLY_MS = 1000; // Delay per restart
    localparam int unsigned OV_WINDOW_S = 60; // Restart counting window
    localparam int unsigned PG_PULSE_MS = 1; // Overload pulse half period
    localparam int unsigned BLINK_MS = 500; // Indicator blink half period
    localparam int unsigned OV_MAX_TRIES = 3; // Failures before latch-off
    // Derived cycle counts
    localparam longint unsigned STARTUP_OVL_CYC =
        longint'(STARTUP_OVL_S) * CLK_HZ;
    localparam longint unsigned OV_RESTART_DLY_CYC =
        longint'(OV_RESTART_DLY_MS) * (CLK_HZ / 1000);
    localparam longint unsigned OV_WINDOW_CYC =
        longint'(OV_WINDOW_S) * CLK_HZ;
    localparam longint unsigned PG_PULSE_CYC =
        longint'(PG_PULSE_MS) * (CLK_HZ / 1000);
    localparam longint unsigned BLINK_CYC =
        longint'(BLINK_MS) * (CLK_HZ / 1000);
    // ----------------------------------------------------------------
    // Supervisor states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RSS_OFF = 3'b000, // Output disabled
        RSS_RUN = 3'b001, // Output delivered
        RSS_SHUT = 3'b011, // Fault shutdown, waiting to retry
        RSS_LATCH = 3'b010 // Latched off
    } rss_state_e;
endpackage

//--- test/rss_host_model.sv
// Host controller model: on/off and mode pins, pulled-up alarm lines
`timescale 1ns/1ns
module rss_host_model (
    input wire logic req_on, // Host wants the output on
    input wire logic link_sel, // Host straps the mode pin to return
    input wire logic link_on, // Host on request in link mode
    input wire logic pg_oe, // Device sinks power-good
    input wire logic flt_oe, // Device sinks fault
    input wire logic warn_oe, // Device sinks overheat warning
    output logic mode_sel_n,
    output logic enable_n,
    output logic link_mode_output_switch,
    output logic pg_pin,
    output logic flt_pin,
    output logic warn_pin
);
    // ---------------------------------------------------------------
    // Control straps
    // ---------------------------------------------------------------
    // Strap to return selects link mode, open line floats high
    assign mode_sel_n = ~link_sel;
    // Enable shorted low to run; dropping it also clears a latch
    assign enable_n = ~req_on;
    assign link_mode_output_switch = link_on;
    // ---------------------------------------------------------------
    // Pulled-up alarm lines
    // ---------------------------------------------------------------
    // A released line reads high through the host pull-up
    assign pg_pin = pg_oe ? 1'b0 : 1'b1;
    assign flt_pin = flt_oe ? 1'b0 : 1'b1;
    assign warn_pin = warn_oe ? 1'b0 : 1'b1;
endmodule // rss_host_model

//--- test/rss_supervisor_bench.sv
// Self-checking bench for the supervisor status logic
`timescale 1ns/1ns
module rss_supervisor_bench;
    // ---------------------------------------------------------------
    // Shortened counts and stimulus
    // ---------------------------------------------------------------
    localparam int STARTUP = 50; // Startup overload allowance
    localparam int RETRY = 10; // Delay before each retry
    localparam int WINDOW = 200; // Retry counting window
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic onoff_sw = 1'b0;
    logic trim_sw = 1'b1;
    logic input_ok = 1'b1;
    logic input_present = 1'b1;
    logic overload = 1'b0;
    logic ov_trip = 1'b0;
    logic oc_trip = 1'b0;
    logic ot_warn = 1'b0;
    logic ot_trip = 1'b0;
    logic boost_fail = 1'b0;
    logic nonfatal_fault = 1'b0;
    logic cmd_off = 1'b0;
    logic service_req = 1'b0;
    logic link_lost = 1'b0;
    logic req_on = 1'b0;
    logic link_sel = 1'b0;
    logic link_on = 1'b0;
    wire logic mode_sel_n, enable_n, link_sw, pg_pin, flt_pin, warn_pin;
    logic use_trim, use_margin, use_default, link_mode, output_on;
    logic latched_off, pg_oe, flt_oe, warn_oe;
    wire logic [3:0] leds; // Input, output, service, fault
    wire logic pg_o, flt_o, warn_o; // Open-drain data, always low
    int n_fail = 0;
    int samples_checked = 0;
    // Free-running 20 MHz clock
    always #25 ref_clk = ~ref_clk;
    rss_supervisor #(.STARTUP_CYC(STARTUP), .RETRY_CYC(RETRY),
        .WINDOW_CYC(WINDOW), .PULSE_CYC(4), .BLINK_HALF_CYC(8)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
        .mode_sel_n(mode_sel_n), .enable_n(enable_n),
        .link_mode_output_switch(link_sw), .onoff_sw(onoff_sw),
        .trim_sw(trim_sw), .input_ok(input_ok),
        .input_present(input_present), .overload(overload),
        .ov_trip(ov_trip), .oc_trip(oc_trip), .ot_warn(ot_warn),
        .ot_trip(ot_trip), .boost_fail(boost_fail),
        .nonfatal_fault(nonfatal_fault), .cmd_off(cmd_off),
        .service_req(service_req), .link_lost(link_lost),
        .use_trim(use_trim), .use_margin(use_margin),
        .use_default(use_default), .link_mode(link_mode),
        .output_on(output_on), .latched_off(latched_off),
        .output_good_flag_o(pg_o), .output_good_flag_oe(pg_oe),
        .fault_o(flt_o), .fault_oe(flt_oe), .overheat_warning_o(warn_o),
        .overheat_warning_oe(warn_oe), .led_input_ok(leds[3]),
        .led_output_ok(leds[2]), .led_service(leds[1]),
        .led_fault(leds[0]));
    rss_host_model u_host (.req_on(req_on), .link_sel(link_sel),
        .link_on(link_on), .pg_oe(pg_oe), .flt_oe(flt_oe),
        .warn_oe(warn_oe), .mode_sel_n(mode_sel_n), .enable_n(enable_n),
        .link_mode_output_switch(link_sw), .pg_pin(pg_pin),
        .flt_pin(flt_pin), .warn_pin(warn_pin));
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    // Single exit point for the run
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", nm, exp, got);
        end
    endtask
    // Sample on falling edges so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Bounded wait for the power stage enable; a hang ends the run
    task automatic wait_on(input logic exp, input int lim);
        int i;
        i = 0;
        while (output_on !== exp && i < lim) begin
            cyc(1);
            i++;
        end
        if (output_on !== exp) begin
            chk("output_on wait", exp, output_on);
            close_out();
        end
    endtask
    // One-cycle overvoltage event taken in the running state
    task automatic trip_ov();
        @(posedge ref_clk) ov_trip <= 1'b1;
        @(posedge ref_clk) ov_trip <= 1'b0;
        wait_on(1'b0, 4);
        cyc(2);
        chk("fault pin ov", 1'b0, flt_pin);
    endtask
    // An indicator must show both levels over three half periods
    task automatic blink(input string nm, input int idx);
        logic [1:0] seen;
        seen = 2'b00;
        repeat (24) begin
            cyc(1);
            seen = seen | {leds[idx] === 1'b1, leds[idx] === 1'b0};
        end
        chk(nm, 1'b1, &seen);
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        int n;
        logic [3:0] ps;
        cyc(4);
        @(posedge ref_clk) nrst <= 1'b1;
        cyc(1);
        chk("pg after reset", 1'b0, pg_pin);
        chk("trim select", 1'b1, use_trim);
        // Start into an overload and time the allowance
        @(posedge ref_clk);
        overload <= 1'b1;
        req_on <= 1'b1;
        wait_on(1'b1, 8);
        n = 0;
        ps = 4'h0;
        while (output_on === 1'b1 && n < 2 * STARTUP) begin
            cyc(1);
            n++;
            ps = ps | {pg_pin === 1'b1, pg_pin === 1'b0,
                leds[2] === 1'b1, leds[2] === 1'b0};
        end
        chk("startup length", 1'b1,
            n >= STARTUP - 2 && n <= STARTUP + 2);
        chk("pg pulse and led blink", 1'b1, &ps);
        @(posedge ref_clk) overload <= 1'b0;
        wait_on(1'b1, RETRY + 10);
        cyc(3);
        chk("pg running", 1'b1, pg_pin);
        @(posedge ref_clk) trim_sw <= 1'b0;
        cyc(4);
        chk("margin select", 1'b1, use_margin);
        chk("default select", 1'b1, use_default);
        // Three overvoltage events in one window latch off
        trip_ov();
        wait_on(1'b1, RETRY + 10);
        trip_ov();
        wait_on(1'b1, RETRY + 10);
        trip_ov();
        cyc(RETRY + 5);
        chk("latched", 1'b1, latched_off);
        chk("no restart", 1'b0, output_on);
        chk("fault led latch", 1'b1, leds[0]);
        chk("input led latch", 1'b1, leds[3]);
        chk("pg latch", 1'b0, pg_pin);
        // Cycle the enable to clear the latch
        @(posedge ref_clk) req_on <= 1'b0;
        cyc(6);
        chk("latch cleared", 1'b0, latched_off);
        @(posedge ref_clk) req_on <= 1'b1;
        wait_on(1'b1, 8);
        // Two events, window expiry, two more: no latch
        for (int k = 0; k < 4; k++) begin
            trip_ov();
            wait_on(1'b1, RETRY + 10);
            if (k == 1) cyc(WINDOW);
        end
        chk("window reset", 1'b0, latched_off);
        // Overcurrent restarts without a fault
        @(posedge ref_clk) oc_trip <= 1'b1;
        @(posedge ref_clk) oc_trip <= 1'b0;
        wait_on(1'b0, 4);
        cyc(2);
        chk("fault pin oc", 1'b1, flt_pin);
        wait_on(1'b1, RETRY + 10);
        // Thermal alarm, then thermal shutdown and recovery
        @(posedge ref_clk) ot_warn <= 1'b1;
        cyc(4);
        chk("warn pin", 1'b0, warn_pin);
        chk("service led", 1'b1, leds[1]);
        chk("pg alarm", 1'b1, pg_pin);
        @(posedge ref_clk) ot_trip <= 1'b1;
        wait_on(1'b0, 6);
        cyc(2);
        chk("fault pin ot", 1'b0, flt_pin);
        chk("fault led ot", 1'b1, leds[0]);
        chk("output led ot", 1'b0, leds[2]);
        chk("pg ot", 1'b0, pg_pin);
        @(posedge ref_clk);
        ot_trip <= 1'b0;
        ot_warn <= 1'b0;
        wait_on(1'b1, RETRY + 10);
        cyc(3);
        chk("warn released", 1'b1, warn_pin);
        // Command off: standby without fault
        @(posedge ref_clk) cmd_off <= 1'b1;
        wait_on(1'b0, 6);
        cyc(2);
        chk("pg standby", 1'b0, pg_pin);
        chk("fault standby", 1'b1, flt_pin);
        chk("output led standby", 1'b0, leds[2]);
        chk("input led standby", 1'b1, leds[3]);
        @(posedge ref_clk) cmd_off <= 1'b0;
        wait_on(1'b1, 8);
        // Internal fault that keeps the output up
        @(posedge ref_clk) nonfatal_fault <= 1'b1;
        cyc(3);
        chk("fault nonfatal", 1'b0, flt_pin);
        chk("pg nonfatal", 1'b1, pg_pin);
        chk("output led nonfatal", 1'b1, leds[2]);
        @(posedge ref_clk) nonfatal_fault <= 1'b0;
        // Boost stage failure
        @(posedge ref_clk) boost_fail <= 1'b1;
        wait_on(1'b0, 6);
        cyc(2);
        chk("fault boost", 1'b0, flt_pin);
        chk("input led boost", 1'b1, leds[3]);
        @(posedge ref_clk) boost_fail <= 1'b0;
        wait_on(1'b1, RETRY + 10);
        // Input out of limits
        @(posedge ref_clk) input_ok <= 1'b0;
        wait_on(1'b0, 6);
        blink("input led blink", 3);
        chk("pg input", 1'b0, pg_pin);
        chk("fault led input", 1'b0, leds[0]);
        @(posedge ref_clk) input_ok <= 1'b1;
        wait_on(1'b1, RETRY + 10);
        @(posedge ref_clk) service_req <= 1'b1;
        blink("service blink", 1);
        @(posedge ref_clk) service_req <= 1'b0;
        // Link mode: enable ignored, link switch in charge
        @(posedge ref_clk) link_sel <= 1'b1;
        wait_on(1'b0, 8);
        chk("link mode", 1'b1, link_mode);
        chk("trim ignored", 1'b0, use_trim);
        chk("margin ignored", 1'b0, use_margin);
        @(posedge ref_clk) link_on <= 1'b1;
        wait_on(1'b1, 8);
        @(posedge ref_clk) req_on <= 1'b0;
        cyc(6);
        chk("enable ignored", 1'b1, output_on);
        @(posedge ref_clk) link_lost <= 1'b1;
        blink("link lost blink", 0);
        @(posedge ref_clk) nonfatal_fault <= 1'b1;
        cyc(3);
        chk("fault unused link", 1'b1, flt_pin);
        // Low clock enable freezes state through a switch drop
        @(posedge ref_clk);
        clk_en <= 1'b0;
        link_on <= 1'b0;
        cyc(6);
        chk("frozen state", 1'b1, output_on);
        // Mid-run reset stands for a power cycle, beating the switch
        @(posedge ref_clk);
        clk_en <= 1'b1;
        nrst <= 1'b0;
        cyc(2);
        chk("power cycle off", 1'b0, output_on);
        chk("drive levels", 1'b0, pg_o | flt_o | warn_o);
        close_out();
    end
endmodule // rss_supervisor_bench
